// *** system_reset_clock_strap_consts.svh ***
/*
  Timing counts and strap decode codes and values for the reset and strap block.
  Assumes inclusion by bare name from design files.
*/
`ifndef SYSTEM_RESET_CLOCK_STRAP_CONSTS_SVH
`define SYSTEM_RESET_CLOCK_STRAP_CONSTS_SVH

`define SYS_CLK_PERIOD_PS     25000
`define RESET_HOLD_TIME_US    100
`define RESET_HOLD_CYCLES     ((`RESET_HOLD_TIME_US * 1000000) / `SYS_CLK_PERIOD_PS)
`define FAST_SEL_33M_A        2'h0
`define FAST_SEL_48M          2'h1
`define FAST_SEL_66M          2'h2
`define FAST_SEL_33M_B        2'h3
`define FAST_KHZ_33M          17'h0_8233
`define FAST_KHZ_48M          17'h0_BB80
`define FAST_KHZ_66M          17'h1_048E
`define BUS_WIDTH_NARROW      5'h08
`define BUS_WIDTH_WIDE        5'h10

`endif

// *** system_reset_clock_strap_pkg.sv ***
/*
  Types for the reset and strap block.
  Assumes no other package.
*/
`default_nettype none
package system_reset_clock_strap_pkg;
  typedef enum logic [1:0] {
    FAST_33M,
    FAST_48M,
    FAST_66M
  } fast_clock_t;

  typedef enum logic [1:0] {
    IN_RESET,
    HOLDING,
    RUNNING
  } reset_state_t;
endpackage
`default_nettype wire

// *** system_reset_clock_strap.sv ***
/*
  Reset sequencer and strap capture: holds the combined reset out while
  power-on reset is asserted and for a fixed time after, latches board
  straps during reset, and forwards the 25 MHz reference.
  Assumes straps are synchronous to sys_clk and pulled low when undriven.
*/
`timescale 1ns/1ps
`default_nettype none
`include "system_reset_clock_strap_consts.svh"

module system_reset_clock_strap #(
  parameter int unsigned HOLD_CYCLES = `RESET_HOLD_CYCLES
) (
  input  wire logic                                sys_clk,
  input  wire logic                                rst,
  input  wire logic                                power_on_reset_in,
  input  wire logic [1:0]                          fast_pci_clock_select_strap,
  input  wire logic [1:0]                          core_multiplier_limit_strap,
  input  wire logic                                wide_boot_bus_strap,
  input  wire logic                                slow_reference_clock_in,
  input  wire logic                                video_reference_clock_in,
  input  wire logic [1:0]                          core_multiplier_request,
  output logic                                     pci_system_reset_out,
  output logic                                     reference_clock_out,
  output logic                                     video_clock_out,
  output logic                                     slow_clock_out,
  output system_reset_clock_strap_pkg::fast_clock_t fastPciClock,
  output logic [16:0]                              fastPciClockKhz,
  output logic [1:0]                               coreMultiplierLimit,
  output logic [1:0]                               coreMultiplier,
  output logic                                     wideBootBus,
  output logic [4:0]                               bootBusWidth
);

  system_reset_clock_strap_pkg::reset_state_t stateQ;
  logic [31:0] holdCountQ;
  logic [1:0]  fastSelQ;
  logic [1:0]  multLimitQ;
  logic        wideBootQ;
  logic        anyReset;

  // Either reset source forces the sequencer back to the start
  assign anyReset = rst | power_on_reset_in;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stateQ     <= system_reset_clock_strap_pkg::IN_RESET;
      holdCountQ <= 32'h0000_0000;
    end else begin
      case (stateQ)
        system_reset_clock_strap_pkg::IN_RESET: begin
          holdCountQ <= 32'h0000_0000;
          if (!power_on_reset_in) begin
            stateQ <= system_reset_clock_strap_pkg::HOLDING;
          end
        end
        system_reset_clock_strap_pkg::HOLDING: begin
          if (power_on_reset_in) begin
            stateQ <= system_reset_clock_strap_pkg::IN_RESET;
          end else if (holdCountQ == HOLD_CYCLES - 1) begin
            stateQ <= system_reset_clock_strap_pkg::RUNNING;
          end else begin
            holdCountQ <= holdCountQ + 32'h0000_0001;
          end
        end
        default: begin
          if (power_on_reset_in) begin
            stateQ <= system_reset_clock_strap_pkg::IN_RESET;
          end
        end
      endcase
    end
  end

  // Output low only once the hold has expired
  assign pci_system_reset_out = anyReset
                              || (stateQ != system_reset_clock_strap_pkg::RUNNING);

  // Cycles spent with reset out high since the supply last let go
  logic [31:0] heldCycles;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      heldCycles <= 32'h0000_0000;
    end else if (power_on_reset_in) begin
      heldCycles <= 32'h0000_0000;
    end else if (pci_system_reset_out) begin
      heldCycles <= heldCycles + 32'h0000_0001;
    end
  end

  // Final counted cycle of the hold, supply still quiet
  sequence holdExpiring;
    stateQ == system_reset_clock_strap_pkg::HOLDING
      && holdCountQ == HOLD_CYCLES - 1
      && !power_on_reset_in;
  endsequence

  sequence supplyQuiet;
    !power_on_reset_in;
  endsequence

  a_reset_during_por: assert property (@(posedge sys_clk) disable iff (rst)
    power_on_reset_in |-> pci_system_reset_out)
    else $error("reset out low during por");

  a_hold_restart: assert property (@(posedge sys_clk) disable iff (rst)
    power_on_reset_in |=> stateQ == system_reset_clock_strap_pkg::IN_RESET)
    else $error("hold not restarted by supply reset");

  a_reset_hold_min: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(pci_system_reset_out) |-> heldCycles >= HOLD_CYCLES)
    else $error("reset out released early");

  a_reset_hold_max: assert property (@(posedge sys_clk) disable iff (rst)
    heldCycles <= HOLD_CYCLES + 2)
    else $error("reset out held too long");

  a_release_on_time: assert property (@(posedge sys_clk) disable iff (rst)
    holdExpiring ##1 supplyQuiet |-> !pci_system_reset_out)
    else $error("reset out not released after hold");

  // Pins decoded ahead of the latch so every strap output comes from a flop
  system_reset_clock_strap_pkg::fast_clock_t fastClockD;
  logic [16:0]                               fastKhzD;
  logic [4:0]                                bootWidthD;

  always_comb begin
    case (fast_pci_clock_select_strap)
      `FAST_SEL_48M: begin
        fastClockD = system_reset_clock_strap_pkg::FAST_48M;
        fastKhzD   = `FAST_KHZ_48M;
      end
      `FAST_SEL_66M: begin
        fastClockD = system_reset_clock_strap_pkg::FAST_66M;
        fastKhzD   = `FAST_KHZ_66M;
      end
      default: begin
        // Both remaining codes select the slow rate
        fastClockD = system_reset_clock_strap_pkg::FAST_33M;
        fastKhzD   = `FAST_KHZ_33M;
      end
    endcase
  end

  assign bootWidthD = wide_boot_bus_strap ? `BUS_WIDTH_WIDE : `BUS_WIDTH_NARROW;

  // Straps track pins while reset is out, freeze at release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fastSelQ        <= 2'h0;
      multLimitQ      <= 2'h0;
      wideBootQ       <= 1'b0;
      fastPciClock    <= system_reset_clock_strap_pkg::FAST_33M;
      fastPciClockKhz <= `FAST_KHZ_33M;
      bootBusWidth    <= `BUS_WIDTH_NARROW;
    end else if (pci_system_reset_out) begin
      fastSelQ        <= fast_pci_clock_select_strap;
      multLimitQ      <= core_multiplier_limit_strap;
      wideBootQ       <= wide_boot_bus_strap;
      fastPciClock    <= fastClockD;
      fastPciClockKhz <= fastKhzD;
      bootBusWidth    <= bootWidthD;
    end
  end

  // Late board changes must never reach the core once running
  a_strap_frozen: assert property (@(posedge sys_clk) disable iff (rst)
    !pci_system_reset_out && !$rose(pci_system_reset_out) |=> $stable(multLimitQ)
      && $stable(fastSelQ) && $stable(wideBootQ) && $stable(fastPciClockKhz))
    else $error("strap changed out of reset");

  a_strap_sampled: assert property (@(posedge sys_clk) disable iff (rst)
    pci_system_reset_out |=> wideBootQ == $past(wide_boot_bus_strap)
      && multLimitQ == $past(core_multiplier_limit_strap))
    else $error("strap not sampled in reset");

  a_fast_select: assert property (@(posedge sys_clk) disable iff (rst)
    fastSelQ == `FAST_SEL_66M |-> fastPciClockKhz == `FAST_KHZ_66M)
    else $error("fast clock decode wrong");

  assign coreMultiplierLimit = multLimitQ;

  logic [1:0] multiplierD;

  // Requests above the strapped ceiling are clamped, never passed
  assign multiplierD = (core_multiplier_request > multLimitQ)
                     ? multLimitQ : core_multiplier_request;

  // Lowest code while in reset: the ceiling is still moving then
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      coreMultiplier <= 2'h0;
    end else if (pci_system_reset_out) begin
      coreMultiplier <= 2'h0;
    end else begin
      coreMultiplier <= multiplierD;
    end
  end

  a_mult_ceiling: assert property (@(posedge sys_clk) disable iff (rst)
    coreMultiplier <= coreMultiplierLimit)
    else $error("multiplier above ceiling");

  assign wideBootBus = wideBootQ;

  a_boot_width: assert property (@(posedge sys_clk) disable iff (rst)
    wideBootBus |-> bootBusWidth == `BUS_WIDTH_WIDE)
    else $error("boot width wrong");

  a_boot_narrow: assert property (@(posedge sys_clk) disable iff (rst)
    !wideBootBus |-> bootBusWidth == `BUS_WIDTH_NARROW)
    else $error("narrow boot width wrong");

  // Reference clocks pass straight through; they are not sys_clk synchronous
  assign reference_clock_out = video_reference_clock_in;
  assign video_clock_out     = video_reference_clock_in;
  assign slow_clock_out      = slow_reference_clock_in;

endmodule
`default_nettype wire

// *** board_model.sv ***
/*
  Board side: power supply reset source, strap resistors and reference clocks.
  Assumes the bench commands the reset request and which straps are driven.
*/
`timescale 1ns/1ps
`default_nettype none
module board_model (
  input  wire logic       porReq,
  input  wire logic [4:0] strapVal,
  input  wire logic [4:0] strapDrv,
  output logic            por,
  output logic [4:0]      strapPin,
  output logic            clk25,
  output logic            clk32k
);
  assign por = porReq;
  // Undriven straps fall to the pull-down level
  assign strapPin = strapVal & strapDrv;
  initial clk25 = 1'b0;
  initial clk32k = 1'b0;
  always #20 clk25 = ~clk25;
  // Never stopped, even with no clock user
  always #15259 clk32k = ~clk32k;
endmodule
`default_nettype wire

// *** system_reset_clock_strap_test.sv ***
/*
  Self-checking bench for the reset and strap block.
  Assumes the board model and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "system_reset_clock_strap_consts.svh"
module system_reset_clock_strap_test;
  localparam int HOLD = 20;
  logic sysClk = 1'b0, rst = 1'b1, porReq = 1'b1, por, clk25, clk32k;
  logic rstOut, refOut, vidOut, slowOut, wide;
  logic [4:0] strapVal = 5'h00, strapDrv = 5'h00, strapPin, width;
  logic [1:0] mulReq = 2'h0, lim, mul;
  logic [16:0] khz;
  logic [31:0] seed = 32'h0000_005A;
  system_reset_clock_strap_pkg::fast_clock_t fast;
  int err_total = 0, cmp_count = 0, cycles = 0;
  board_model board_u (.porReq(porReq), .strapVal(strapVal), .strapDrv(strapDrv), .por(por),
    .strapPin(strapPin), .clk25(clk25), .clk32k(clk32k));
  system_reset_clock_strap #(.HOLD_CYCLES(HOLD)) dut_u (.sys_clk(sysClk), .rst(rst),
    .power_on_reset_in(por), .fast_pci_clock_select_strap(strapPin[1:0]),
    .core_multiplier_limit_strap(strapPin[3:2]), .wide_boot_bus_strap(strapPin[4]),
    .slow_reference_clock_in(clk32k), .video_reference_clock_in(clk25),
    .core_multiplier_request(mulReq), .pci_system_reset_out(rstOut),
    .reference_clock_out(refOut), .video_clock_out(vidOut), .slow_clock_out(slowOut),
    .fastPciClock(fast), .fastPciClockKhz(khz), .coreMultiplierLimit(lim),
    .coreMultiplier(mul), .wideBootBus(wide), .bootBusWidth(width));
  always #12.5 sysClk = ~sysClk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [16:0] expKhz(input logic [1:0] s);
    return s == 2'h1 ? `FAST_KHZ_48M : s == 2'h2 ? `FAST_KHZ_66M : `FAST_KHZ_33M;
  endfunction
  task automatic cmp(input string nm, input logic [16:0] e, input logic [16:0] g);
    cmp_count++;
    if (e !== g) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Ceiling well above eleven short tests
  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic runOne(input logic [4:0] v, input logic [4:0] d, input logic abort);
    logic [4:0] e;
    int n;
    e = v & d;
    porReq = 1'b1;
    strapVal = v;
    strapDrv = d;
    repeat (3) @(negedge sysClk);
    cmp("rstOut", 17'h1, {16'h0, rstOut});
    porReq = 1'b0;
    if (abort) begin
      repeat (HOLD / 2) @(negedge sysClk);
      porReq = 1'b1;
      @(negedge sysClk);
      cmp("rstOutPor", 17'h1, {16'h0, rstOut});
      porReq = 1'b0;
    end
    n = 0;
    while (rstOut === 1'b1 && n < HOLD + 10) begin
      @(negedge sysClk);
      n++;
    end
    cmp("holdLen", 17'(HOLD + 1), 17'(n));
    // Late strap changes must not reach the latched values
    strapVal = ~v;
    strapDrv = 5'h1F;
    @(negedge sysClk);
    cmp("khz", expKhz(e[1:0]), khz);
    cmp("fast", {15'h0, e[1:0] == 2'h3 ? 2'h0 : e[1:0]}, {15'h0, fast});
    cmp("lim", {15'h0, e[3:2]}, {15'h0, lim});
    for (int r = 0; r < 4; r++) begin
      mulReq = 2'(r);
      @(negedge sysClk);
      cmp("mul", {15'h0, mulReq > e[3:2] ? e[3:2] : mulReq}, {15'h0, mul});
    end
    cmp("wide", {16'h0, e[4]}, {16'h0, wide});
    cmp("width", {12'h0, e[4] ? `BUS_WIDTH_WIDE : `BUS_WIDTH_NARROW}, {12'h0, width});
    cmp("refOut", {16'h0, clk25}, {16'h0, refOut});
    cmp("vidOut", {16'h0, clk25}, {16'h0, vidOut});
    cmp("slowOut", {16'h0, clk32k}, {16'h0, slowOut});
    $display("Test done, straps %0h", e);
  endtask
  initial begin
    repeat (12) @(negedge sysClk);
    cmp("rstOutInReset", 17'h1, {16'h0, rstOut});
    rst = 1'b0;
    for (int i = 0; i < 4; i++) runOne({i[0], 2'(3 - i), 2'(i)}, 5'h1F, i == 2);
    // Mid-run reset wipes the latched straps
    rst = 1'b1;
    @(negedge sysClk);
    cmp("limInRst", 17'h0, {15'h0, lim});
    cmp("wideInRst", 17'h0, {16'h0, wide});
    cmp("widthInRst", {12'h0, `BUS_WIDTH_NARROW}, {12'h0, width});
    cmp("rstOutInRst", 17'h1, {16'h0, rstOut});
    rst = 1'b0;
    runOne(5'h1F, 5'h00, 1'b0);
    repeat (6) begin
      seed = xs(seed);
      runOne(seed[4:0], seed[9:5], seed[10]);
    end
    end_sim();
  end
endmodule
`default_nettype wire
